// ### core/pifr_top.sv
/*
 * pifr_top: peripheral interrupt flags, enables and reset-cause
 * status behind a classic Wishbone slave.
 * Assumes all peripherals and the bus share clock_i; events are
 * same-clock pulses, rx_full and tx_empty are buffer levels.
 */
// Local design decision: the Wishbone slave port.
// How it works
// - peripheral events set their flag regardless of any enable bit.
// - unimplemented bits always read zero in every register.
// - converter-done flag sets on conversion end; zero without converter.
// - receive-full flag mirrors the receive buffer level, read-only.
// - transmit-empty flag mirrors the transmit buffer level, read-only.
// - sync port flag sets on transfer complete, software clears.
// - capture/compare flag sets on capture in capture mode, compare match in compare mode, not in PWM.
// - timer-two flag sets on period match, software clears.
// - timer-one flag sets on overflow, software clears.
// - second enable register holds oscillator, comparator, EEPROM enables.
// - oscillator-fail flag sets on clock failover, software clears.
// - comparator flag sets on any comparator change, software clears.
// - EEPROM flag sets on write completion, software clears.
// - power-on reset clears power-on bit; software then sets it.
// - brown-out reset clears brown-out bit; software then sets it.
// - brown-out bit undefined after power-on, meaningless when detect off.
// - flags, enables and power-on bit reset to zero.
// - peripheral requests need the peripheral interrupt enable.
// - global enable gates every interrupt.
// - first enable register mirrors first flag register positions.
`timescale 1ns/1ns
module pifr_top #(
	parameter bit HAS_CONVERTER = 1'b1 // converter variant present
) (
	input wire logic clock_i, // 25 MHz system clock
	input wire logic reset_i, // power-on reset, sync, high
	input wire logic wb_cyc_i, // bus cycle
	input wire logic wb_stb_i, // strobe
	input wire logic wb_we_i, // write enable
	input wire logic [9:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte lanes
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // acknowledge
	input wire pifr_pkg::pifr_events_s events_i, // peripheral events
	input wire pifr_pkg::pifr_ccp_mode_e ccp_mode_i, // ccp mode
	input wire logic brownout_detect_enable_i, // config bit
	output logic periph_irq_o // interrupt request
);
	// bus state
	logic ack_reg;
	logic ack_next;
	logic [31:0] dat_reg;
	logic [31:0] dat_next;

	// register state
	logic [7:0] en_one_reg;
	logic [7:0] en_one_next;
	logic [7:0] en_two_reg;
	logic [7:0] en_two_next;
	logic [7:0] ctrl_reg;
	logic [7:0] ctrl_next;
	logic rx_reg;
	logic tx_reg;
	logic por_reg;
	logic por_next;
	logic bor_reg;
	logic bor_next;
	logic irq_reg;
	logic irq_next;

	// decode wires
	logic req;
	logic wr_now;
	logic [7:0] idx;
	logic [7:0] wbyte;
	logic hit_ctrl;
	logic hit_f1;
	logic hit_f2;
	logic hit_e1;
	logic hit_e2;
	logic hit_st;
	logic [7:0] rd_byte;

	// flag wiring
	logic [7:0] set_one;
	logic [7:0] set_two;
	logic [7:0] flags_one_q;
	logic [7:0] flags_two_q;
	logic [7:0] flags_one;
	logic [7:0] flags_two;
	logic [7:0] mask_one;
	logic ccp_hit;
	logic bor_hit;
	logic pend;

	// bus decode; a write lands on the edge the master sees ack
	assign req = wb_cyc_i & wb_stb_i;
	assign ack_next = req & ~ack_reg;
	assign wr_now = req & wb_we_i & ack_reg & wb_sel_i[0];
	assign idx = wb_adr_i[9:2];
	assign wbyte = wb_dat_i[7:0];
	assign hit_ctrl = (idx == pifr_pkg::IDX_CORE_CTRL);
	assign hit_f1 = (idx == pifr_pkg::IDX_FLAGS_ONE);
	assign hit_f2 = (idx == pifr_pkg::IDX_FLAGS_TWO);
	assign hit_e1 = (idx == pifr_pkg::IDX_ENABLES_ONE);
	assign hit_e2 = (idx == pifr_pkg::IDX_ENABLES_TWO);
	assign hit_st = (idx == pifr_pkg::IDX_RESET_STATUS);

	// without a converter bit 6 is dead in both first registers
	assign mask_one = HAS_CONVERTER ? pifr_pkg::MASK_ONE
		: pifr_pkg::MASK_ONE_NOCONV;

	// capture/compare event qualified by mode; PWM never sets it
	assign ccp_hit =
		(events_i.capture & (ccp_mode_i == pifr_pkg::PIFR_CCP_CAPTURE))
		| (events_i.compare_match
		& (ccp_mode_i == pifr_pkg::PIFR_CCP_COMPARE));

	// set vector for the first sticky group
	always_comb
	begin
		set_one = 8'h00;
		set_one[pifr_pkg::BIT_CONV] = events_i.conv_done
			& HAS_CONVERTER;
		set_one[pifr_pkg::BIT_SYNC] = events_i.sync_done;
		set_one[pifr_pkg::BIT_CCP] = ccp_hit;
		set_one[pifr_pkg::BIT_TIMER_TWO_COUNT] = events_i.timer_two_match;
		set_one[pifr_pkg::BIT_TIMER_ONE_COUNT] = events_i.timer_one_overflow;
	end

	// set vector for the second sticky group
	always_comb
	begin
		set_two = 8'h00;
		set_two[pifr_pkg::BIT_OSC] = events_i.osc_fail;
		set_two[pifr_pkg::BIT_CMP] = events_i.comparator_change;
		set_two[pifr_pkg::BIT_EE] = events_i.eeprom_write_done;
	end

	// one sticky cell per implemented writable flag
	genvar g;
	generate
		for (g = 0; g < 8; g++)
		begin : g_flag
			if (pifr_pkg::MASK_RW_ONE[g])
			begin : g_one
				pifr_flag_bit u_bit (
					.clock_i(clock_i),
					.reset_i(reset_i),
					.set_i(set_one[g]),
					.wr_i(wr_now & hit_f1),
					.wdata_i(wbyte[g] & mask_one[g]),
					.flag_o(flags_one_q[g])
				);
			end
			else
			begin : g_one_none
				assign flags_one_q[g] = 1'b0;
			end
			if (pifr_pkg::MASK_TWO[g])
			begin : g_two
				pifr_flag_bit u_bit (
					.clock_i(clock_i),
					.reset_i(reset_i),
					.set_i(set_two[g]),
					.wr_i(wr_now & hit_f2),
					.wdata_i(wbyte[g]),
					.flag_o(flags_two_q[g])
				);
			end
			else
			begin : g_two_none
				assign flags_two_q[g] = 1'b0;
			end
		end
	endgenerate

	// buffer levels join the sticky flags; they ignore writes
	always_comb
	begin
		flags_one = flags_one_q & mask_one;
		flags_one[pifr_pkg::BIT_RX] = rx_reg;
		flags_one[pifr_pkg::BIT_TX] = tx_reg;
	end
	assign flags_two = flags_two_q & pifr_pkg::MASK_TWO;

	// enable and control writes, unimplemented bits masked off
	assign en_one_next = (wr_now & hit_e1) ? (wbyte & mask_one)
		: en_one_reg;
	assign en_two_next = (wr_now & hit_e2) ? (wbyte & pifr_pkg::MASK_TWO)
		: en_two_reg;
	assign ctrl_next = (wr_now & hit_ctrl) ? (wbyte & pifr_pkg::MASK_CTRL)
		: ctrl_reg;

	// reset-cause bits; software sets them to tell later resets apart
	assign por_next = (wr_now & hit_st) ? wbyte[pifr_pkg::BIT_POR]
		: por_reg;
	// brown-out reset beats a write; ignored when detection is off
	assign bor_hit = events_i.brownout_reset & brownout_detect_enable_i;
	assign bor_next = bor_hit ? 1'b0
		: ((wr_now & hit_st) ? wbyte[pifr_pkg::BIT_BOR] : bor_reg);

	// request: any flag with its enable, then both gate bits
	assign pend = (|(flags_one & en_one_reg))
		| (|(flags_two & en_two_reg));
	assign irq_next = pend & ctrl_reg[pifr_pkg::BIT_PERIPHERAL_IRQ_ENABLE]
		& ctrl_reg[pifr_pkg::BIT_GIE];

	// read mux; unmapped indices answer zero
	assign rd_byte = hit_ctrl ? ctrl_reg
		: hit_f1 ? flags_one
		: hit_f2 ? flags_two
		: hit_e1 ? en_one_reg
		: hit_e2 ? en_two_reg
		: hit_st ? {6'h00, por_reg, bor_reg}
		: 8'h00;
	assign dat_next = ack_next ? {24'h000000, rd_byte} : 32'h00000000;

	// bus answer registers
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h00000000;
		end
		else
		begin
			ack_reg <= ack_next;
			dat_reg <= dat_next;
		end
	end

	// enables, control and request output
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			en_one_reg <= pifr_pkg::RST_ENABLES;
			en_two_reg <= pifr_pkg::RST_ENABLES;
			ctrl_reg <= pifr_pkg::RST_CTRL;
			irq_reg <= 1'b0;
		end
		else
		begin
			en_one_reg <= en_one_next;
			en_two_reg <= en_two_next;
			ctrl_reg <= ctrl_next;
			irq_reg <= irq_next;
		end
	end

	// buffer mirrors, one cycle behind the serial unit
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			rx_reg <= 1'b0;
			tx_reg <= 1'b0;
		end
		else
		begin
			rx_reg <= events_i.rx_full;
			tx_reg <= events_i.tx_empty;
		end
	end

	// reset cause; brown-out bit has no real meaning after power-on
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			por_reg <= pifr_pkg::RST_POR;
			bor_reg <= pifr_pkg::RST_BOR;
		end
		else
		begin
			por_reg <= por_next;
			bor_reg <= bor_next;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;
	assign periph_irq_o = irq_reg;

	// checks, all on the system clock
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (reset_i);

	a_timer_one_set: assert property (
		events_i.timer_one_overflow |=> flags_one[pifr_pkg::BIT_TIMER_ONE_COUNT])
		else $error("timer one overflow did not set its flag");

	a_rx_level_mirror: assert property (
		##1 (flags_one[pifr_pkg::BIT_RX] == $past(events_i.rx_full)))
		else $error("receive flag does not follow buffer level");

	a_ccp_pwm_quiet: assert property (
		(ccp_mode_i == pifr_pkg::PIFR_CCP_PWM) && !flags_one[2]
		&& !(wr_now && hit_f1) |=> !flags_one[pifr_pkg::BIT_CCP])
		else $error("capture flag set in pwm mode");

	a_global_gate: assert property (
		!ctrl_reg[pifr_pkg::BIT_GIE] |=> !periph_irq_o)
		else $error("request raised with global enable low");

	a_periph_gate: assert property (
		!ctrl_reg[pifr_pkg::BIT_PERIPHERAL_IRQ_ENABLE] |=> !periph_irq_o)
		else $error("request raised with peripheral enable low");

	a_irq_raised: assert property (
		(pend && ctrl_reg[7] && ctrl_reg[6]) |=> periph_irq_o)
		else $error("enabled pending flag gave no request");

	a_unimpl_zero: assert property (
		(wb_ack_o && !wb_we_i && hit_f2) |->
		(wb_dat_o[5] == 1'b0) && (wb_dat_o[3:0] == 4'h0))
		else $error("unimplemented bits of second flags read high");

	a_set_beats_clear: assert property (
		(events_i.comparator_change && wr_now && hit_f2
		&& !wbyte[pifr_pkg::BIT_CMP]) |=> flags_two[pifr_pkg::BIT_CMP])
		else $error("comparator event lost to a clear");

	a_por_after_reset: assert property (
		$fell(reset_i) |-> (por_reg == 1'b0) && (flags_two == 8'h00))
		else $error("power-on bit or flags not cleared by reset");

	a_brownout_clear: assert property (
		bor_hit |=> !bor_reg)
		else $error("brown-out reset did not clear its bit");

endmodule : pifr_top

// ### core/pifr_pkg.sv
/*
 * pifr_pkg: register indices, bit positions, masks, reset values and
 * carrier types for the peripheral flag bank.
 * Assumes a Wishbone slave that maps register index n at byte 4*n.
 */
package pifr_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_CORE_CTRL = 8'h0b;
	localparam logic [7:0] IDX_FLAGS_ONE = 8'h0c;
	localparam logic [7:0] IDX_FLAGS_TWO = 8'h0d;
	localparam logic [7:0] IDX_ENABLES_ONE = 8'h8c;
	localparam logic [7:0] IDX_ENABLES_TWO = 8'h8d;
	localparam logic [7:0] IDX_RESET_STATUS = 8'h8e;

	// first flag and enable pair
	localparam int BIT_CONV = 6;
	localparam int BIT_RX = 5;
	localparam int BIT_TX = 4;
	localparam int BIT_SYNC = 3;
	localparam int BIT_CCP = 2;
	localparam int BIT_TIMER_TWO_COUNT = 1;
	localparam int BIT_TIMER_ONE_COUNT = 0;

	// second flag and enable pair
	localparam int BIT_OSC = 7;
	localparam int BIT_CMP = 6;
	localparam int BIT_EE = 4;

	// core control and reset status
	localparam int BIT_GIE = 7;
	localparam int BIT_PERIPHERAL_IRQ_ENABLE = 6;
	localparam int BIT_POR = 1;
	localparam int BIT_BOR = 0;

	// implemented and software-writable bits
	localparam logic [7:0] MASK_ONE = 8'h7f;
	localparam logic [7:0] MASK_ONE_NOCONV = 8'h3f;
	localparam logic [7:0] MASK_RW_ONE = 8'h4f;
	localparam logic [7:0] MASK_TWO = 8'hd0;
	localparam logic [7:0] MASK_CTRL = 8'hc0;

	// reset values
	localparam logic [7:0] RST_ENABLES = 8'h00;
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic RST_FLAG = 1'b0;
	localparam logic RST_POR = 1'b0;
	localparam logic RST_BOR = 1'b0;

	// capture/compare unit mode
	typedef enum logic [2:0] {
		PIFR_CCP_CAPTURE = 3'b001,
		PIFR_CCP_COMPARE = 3'b010,
		PIFR_CCP_PWM = 3'b100
	} pifr_ccp_mode_e;

	// peripheral events, one-cycle pulses except the two buffer levels
	typedef struct packed {
		logic conv_done;
		logic rx_full;
		logic tx_empty;
		logic sync_done;
		logic capture;
		logic compare_match;
		logic timer_two_match;
		logic timer_one_overflow;
		logic osc_fail;
		logic comparator_change;
		logic eeprom_write_done;
		logic brownout_reset;
	} pifr_events_s;

endpackage : pifr_pkg

// ### core/pifr_flag_bit.sv
/*
 * pifr_flag_bit: one sticky interrupt flag, set by hardware,
 * written by software.
 * Assumes set_i and wr_i are on clock_i.
 */
`timescale 1ns/1ns
module pifr_flag_bit (
	input wire logic clock_i, // system clock
	input wire logic reset_i, // sync reset, high
	input wire logic set_i, // hardware event
	input wire logic wr_i, // software write strobe
	input wire logic wdata_i, // written value
	output logic flag_o // flag state
);
	logic flag_reg;
	logic flag_next;

	// event wins over a write in the same cycle
	assign flag_next = set_i | (wr_i ? wdata_i : flag_reg);

	// flag storage
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
			flag_reg <= pifr_pkg::RST_FLAG;
		else
			flag_reg <= flag_next;
	end

	assign flag_o = flag_reg;

endmodule : pifr_flag_bit

// ### bench/pifr_periph_model.sv
/*
 * pifr_periph_model: peripherals beside the flag bank.
 * Assumes pulse requests on clock_i, one cycle long.
 */
`timescale 1ns/1ns
module pifr_periph_model (
	input wire logic clock_i, // system clock
	input wire logic reset_i, // sync reset, high
	input wire logic [11:0] pulse_i, // event pulses, struct order
	input wire logic rx_read_i, // core reads receive data
	input wire logic tx_write_i, // core writes transmit data
	output pifr_pkg::pifr_events_s events_o // events to the bank
);
	logic rx_level_reg;
	logic tx_level_reg;
	// buffer levels; transmitter held off after reset, so empty reads low
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			rx_level_reg <= 1'b0;
			tx_level_reg <= 1'b0;
		end
		else
		begin
			rx_level_reg <= (rx_level_reg | pulse_i[10]) & ~rx_read_i;
			tx_level_reg <= (tx_level_reg | pulse_i[9]) & ~tx_write_i;
		end
	end
	// levels stand in for the two buffer pulse bits
	assign events_o = {pulse_i[11], rx_level_reg, tx_level_reg, pulse_i[8:0]};
endmodule : pifr_periph_model

// ### bench/test_pifr_top.sv
/*
 * test_pifr_top: self-checking bench for the peripheral flag bank.
 * Assumes one-cycle Wishbone answers and the partner model beside it.
 */
`timescale 1ns/1ns
module test_pifr_top;
	logic clock_i = 1'b0;
	logic reset_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [9:0] adr = 10'h000;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic ack;
	logic [11:0] pulse = 12'h000;
	logic rx_read = 1'b0;
	logic tx_write = 1'b0;
	pifr_pkg::pifr_events_s events;
	pifr_pkg::pifr_ccp_mode_e mode = pifr_pkg::PIFR_CCP_CAPTURE;
	logic bor_en = 1'b1;
	logic irq;
	int fails = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [31:0] rd;
	logic [31:0] rdat_nc;
	logic [31:0] rd_nc;
	localparam int EV[7] = '{11, 8, 5, 4, 3, 2, 1};
	localparam logic [7:0] RIX[7] = '{8'h0c, 8'h0c, 8'h0c, 8'h0c, 8'h0d, 8'h0d, 8'h0d};
	localparam logic [7:0] MK[7] = '{8'h40, 8'h08, 8'h02, 8'h01, 8'h80, 8'h40, 8'h10};
	localparam logic [7:0] AIX[6] = '{8'h0b, 8'h0c, 8'h0d, 8'h8c, 8'h8d, 8'h8e};
	localparam logic [7:0] AMK[6] = '{8'hc0, 8'h4f, 8'hd0, 8'h7f, 8'hd0, 8'h03};

	pifr_top #(.HAS_CONVERTER(1'b1)) dut (.clock_i(clock_i), .reset_i(reset_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .events_i(events),
		.ccp_mode_i(mode), .brownout_detect_enable_i(bor_en), .periph_irq_o(irq));
	// variant without converter on the same bus; both answer on the same edge
	pifr_top #(.HAS_CONVERTER(1'b0)) dut_nc (.clock_i(clock_i), .reset_i(reset_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat_nc), .wb_ack_o(), .events_i(events),
		.ccp_mode_i(mode), .brownout_detect_enable_i(bor_en), .periph_irq_o());
	pifr_periph_model periph (.clock_i(clock_i), .reset_i(reset_i), .pulse_i(pulse),
		.rx_read_i(rx_read), .tx_write_i(tx_write), .events_o(events));

	always #20 clock_i = ~clock_i;
	// hang guard; whole run needs well under 2000 cycles
	always @(posedge clock_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			fails = fails + 1;
			close_out();
		end
	end

	task close_out;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done = checks_done + 1;
		if (seen !== exp)
		begin
			fails = fails + 1;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// one classic cycle; read data taken at the ack edge only
	task xfer(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] s);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		sel <= s;
		wdat <= {24'h0, d};
		do @(posedge clock_i); while (ack !== 1'b1);
		rd = rdat;
		rd_nc = rdat_nc;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clock_i);
	endtask : xfer

	task wr(input logic [7:0] idx, input logic [7:0] d);
		xfer(1'b1, idx, d, 4'h1);
	endtask : wr

	task rd_is(input logic [7:0] idx, input logic [7:0] exp);
		xfer(1'b0, idx, 8'h00, 4'h1);
		check(rd, {24'h0, exp});
	endtask : rd_is

	task fire(input logic [11:0] v);
		pulse <= v;
		@(posedge clock_i);
		pulse <= 12'h000;
	endtask : fire

	task irq_is(input logic exp);
		@(posedge clock_i);
		check({31'h0, irq}, {31'h0, exp});
	endtask : irq_is

	task do_reset;
		reset_i <= 1'b1;
		repeat (12) @(posedge clock_i);
		reset_i <= 1'b0;
		@(posedge clock_i);
	endtask : do_reset

	// reset values, writable masks, lane-0 gating, unmapped index
	task t_regs;
		for (int i = 0; i < 6; i++)
			rd_is(AIX[i], 8'h00);
		rd_is(8'h20, 8'h00);
		for (int i = 0; i < 6; i++)
			wr(AIX[i], 8'hff);
		for (int i = 0; i < 6; i++)
			rd_is(AIX[i], AMK[i]);
		rd_is(8'h0c, 8'h4f);
		check(rd_nc, 32'h0000000f);
		rd_is(8'h8c, 8'h7f);
		check(rd_nc, 32'h0000003f);
		irq_is(1'b1);
		for (int i = 0; i < 6; i++)
			wr(AIX[i], 8'h00);
		xfer(1'b1, 8'h8d, 8'hff, 4'h0);
		rd_is(8'h8d, 8'h00);
	endtask : t_regs

	// every pulsed flag source except capture/compare sets its own flag with all enables off
	task t_events;
		for (int i = 0; i < 7; i++)
		begin
			fire(12'h001 << EV[i]);
			rd_is(RIX[i], MK[i]);
			if (i == 0)
				check(rd_nc, 32'h00000000);
			wr(RIX[i], 8'h00);
			rd_is(RIX[i], 8'h00);
		end
		irq_is(1'b0);
	endtask : t_events

	// capture/compare source follows the unit's mode
	task t_ccp;
		fire(12'h0c0);
		rd_is(8'h0c, 8'h04);
		wr(8'h0c, 8'h00);
		mode <= pifr_pkg::PIFR_CCP_COMPARE;
		fire(12'h080);
		rd_is(8'h0c, 8'h00);
		fire(12'h040);
		rd_is(8'h0c, 8'h04);
		wr(8'h0c, 8'h00);
		mode <= pifr_pkg::PIFR_CCP_PWM;
		fire(12'h0c0);
		rd_is(8'h0c, 8'h00);
	endtask : t_ccp

	// buffer flags follow levels; a write of zero must not clear them
	task t_serial;
		fire(12'h600);
		@(posedge clock_i);
		wr(8'h0c, 8'h00);
		rd_is(8'h0c, 8'h30);
		rx_read <= 1'b1;
		tx_write <= 1'b1;
		@(posedge clock_i);
		rx_read <= 1'b0;
		tx_write <= 1'b0;
		@(posedge clock_i);
		rd_is(8'h0c, 8'h00);
	endtask : t_serial

	// request gating by both control bits and both register pairs
	task t_irq;
		wr(8'h0c, 8'h00);
		wr(8'h8c, 8'h01);
		wr(8'h0b, 8'hc0);
		fire(12'h010);
		@(posedge clock_i);
		irq_is(1'b1);
		wr(8'h0b, 8'h80);
		irq_is(1'b0);
		wr(8'h0b, 8'h40);
		irq_is(1'b0);
		wr(8'h0b, 8'hc0);
		irq_is(1'b1);
		wr(8'h8c, 8'h00);
		irq_is(1'b0);
		fire(12'h004);
		wr(8'h8d, 8'h40);
		irq_is(1'b1);
		wr(8'h0d, 8'h00);
		irq_is(1'b0);
		wr(8'h0b, 8'h00);
		wr(8'h8d, 8'h00);
	endtask : t_irq

	// event lands on the very edge that a clearing write takes effect
	task t_collide;
		fork
			wr(8'h0c, 8'h00);
			begin
				@(posedge clock_i);
				fire(12'h010);
			end
		join
		rd_is(8'h0c, 8'h01);
		wr(8'h0c, 8'h00);
		// same race on the second group, comparator against a clear
		fork
			wr(8'h0d, 8'h00);
			begin
				@(posedge clock_i);
				fire(12'h004);
			end
		join
		rd_is(8'h0d, 8'h40);
		wr(8'h0d, 8'h00);
	endtask : t_collide

	// reset-cause bits: brown-out event, detector off, power-on reset
	task t_status;
		wr(8'h8e, 8'h03);
		fire(12'h001);
		rd_is(8'h8e, 8'h02);
		wr(8'h8e, 8'h03);
		bor_en <= 1'b0;
		fire(12'h001);
		rd_is(8'h8e, 8'h03);
		bor_en <= 1'b1;
		do_reset();
		xfer(1'b0, 8'h8e, 8'h00, 4'h1);
		check(rd & 32'h2, 32'h0);
	endtask : t_status

	initial
	begin
		do_reset();
		t_regs();
		t_events();
		t_ccp();
		t_serial();
		t_irq();
		t_collide();
		t_status();
		close_out();
	end
endmodule : test_pifr_top
